//--- rtl/svw_pkg.sv
/*
 * package for the supply supervisor / watchdog reset block: timing constants,
 * register map, field positions, reset values and carrier types.
 * assumes a 50 MHz core clock.
 */
package svw_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned HOLD_MS         = 250;   // power-up and brownout hold
  localparam int unsigned HOLD_ALT_MS     = 200;   // alternative brownout hold figure
  localparam int unsigned WD_LONG_MS      = 1400;  // select 00
  localparam int unsigned WD_MID_MS       = 600;   // select 01
  localparam int unsigned WD_SHORT_MS     = 200;   // select 10
  localparam int unsigned HOLD_CYC        = HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLD_ALT_CYC    = HOLD_ALT_MS * (CLK_HZ / 1000);
  localparam int unsigned WD_LONG_CYC     = WD_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned WD_MID_CYC      = WD_MID_MS * (CLK_HZ / 1000);
  localparam int unsigned WD_SHORT_CYC    = WD_SHORT_MS * (CLK_HZ / 1000);

  // ****************************************************************
  // register map (byte addresses, word index = addr[4:2])
  // ****************************************************************
  localparam logic [2:0] REG_CTRL   = 3'h0;  // protect enable + period select
  localparam logic [2:0] REG_STATUS = 3'h1;  // sticky events, read only
  localparam logic [2:0] REG_CLEAR  = 3'h2;  // write one to clear status
  localparam logic [2:0] REG_IRQEN  = 3'h3;  // interrupt enable
  localparam logic [2:0] REG_STATE  = 3'h4;  // live state, read only
  localparam logic [2:0] REG_NVCMD  = 3'h5;  // start nonvolatile write cycle

  // ctrl fields
  localparam int CTRL_SEL_LO  = 0;
  localparam int CTRL_SEL_HI  = 1;
  localparam int CTRL_PROTECT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h3;  // watchdog disabled, protect off

  // status / enable bits
  localparam int EV_WATCHDOG = 0;
  localparam int EV_BROWNOUT = 1;
  localparam int EV_REFUSED  = 2;
  localparam int EV_ABORT    = 3;
  localparam int EV_W        = 4;

  localparam logic [1:0] SEL_DISABLED = 2'h3;

  typedef enum logic [1:0] {
    SVW_RUN  = 2'b00,
    SVW_LOW  = 2'b01,
    SVW_HOLD = 2'b10
  } svw_state_e;

  // pin sample carrier
  typedef struct packed {
    logic supplyOk;
    logic sclIn;
    logic sdaIn;
    logic wpIn;
  } svw_pins_s;

endpackage : svw_pkg

//--- rtl/svw_supervisor.sv
/*
 * supply supervisor and watchdog reset generator with an avalon-mm slave.
 * assumes pins are asynchronous to core_clk, the bus master obeys
 * waitrequest, and the pad resolves the open-drain reset and data wires.
 */
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/100ps
module svw_supervisor #(
  parameter bit          ACTIVE_HIGH  = 1'b0,
  parameter int unsigned HOLD_CYC     = svw_pkg::HOLD_CYC,
  parameter int unsigned WD_LONG_CYC  = svw_pkg::WD_LONG_CYC,
  parameter int unsigned WD_MID_CYC   = svw_pkg::WD_MID_CYC,
  parameter int unsigned WD_SHORT_CYC = svw_pkg::WD_SHORT_CYC,
  parameter int unsigned NV_CYC       = 250_000
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  // supply comparator and pins
  input  wire logic        supplyAboveTrip,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  input  wire logic        wpIn,
  output logic             resetOut,
  output logic             resetOe,
  output logic             busAbort,
  output logic             busBlocked,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  svw_pkg::svw_pins_s pinMeta_ff, pinSync_ff, pinStab_ff, pinClean_ff;
  svw_pkg::svw_pins_s pinRaw;
  assign pinRaw = '{supplyOk: supplyAboveTrip, sclIn: sclIn, sdaIn: sdaIn, wpIn: wpIn};

  // three stages; accepted when second and third agree
  always_ff @(posedge core_clk) begin
    pinMeta_ff <= pinRaw;
    pinSync_ff <= pinMeta_ff;
    pinStab_ff <= pinSync_ff;
  end

  // data path is never gated by bus state or supervisor reset; rst clears the filtered copy
  svw_pkg::svw_pins_s nxt_pinClean;
  generate
    for (genvar i = 0; i < 4; i++) begin : g_filt
      assign nxt_pinClean[i] = (pinSync_ff[i] == pinStab_ff[i]) ? pinStab_ff[i] : pinClean_ff[i];
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst) pinClean_ff <= '0;
    else     pinClean_ff <= nxt_pinClean;
  end

  // start condition: data falls while clock stays high
  logic startSeen;
  assign startSeen = pinClean_ff.sdaIn & ~nxt_pinClean.sdaIn & pinClean_ff.sclIn & nxt_pinClean.sclIn;

  // ****************************************************************
  // control register
  // ****************************************************************
  logic [2:0] ctrl_ff;
  logic       hwProtect;
  // protection only when pin and enable bit are both high
  assign hwProtect = pinClean_ff.wpIn & ctrl_ff[svw_pkg::CTRL_PROTECT];

  // watchdog period decode
  function automatic logic [31:0] wdLimit(input logic [1:0] sel);
    unique case (sel)
      2'b00:   wdLimit = 32'(WD_LONG_CYC);
      2'b01:   wdLimit = 32'(WD_MID_CYC);
      2'b10:   wdLimit = 32'(WD_SHORT_CYC);
      2'b11:   wdLimit = 32'h0000_0000;
    endcase
  endfunction : wdLimit

  logic [1:0]  wdSel;
  logic        wdEnabled;
  logic [31:0] wdLimitCyc;
  assign wdSel      = {ctrl_ff[svw_pkg::CTRL_SEL_HI], ctrl_ff[svw_pkg::CTRL_SEL_LO]};
  assign wdEnabled  = (wdSel != svw_pkg::SEL_DISABLED);
  assign wdLimitCyc = wdLimit(wdSel);

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic [2:0] regIdx;
  logic       wrAcc, rdAcc, ctrlWr, clrWr, enWr, nvWr, ctrlRefused;
  logic       respond_ff;
  logic       resetActive;
  assign regIdx      = avs_address[4:2];
  assign wrAcc       = avs_write & ~respond_ff;
  assign rdAcc       = avs_read & ~respond_ff;
  assign ctrlWr      = wrAcc & (regIdx == svw_pkg::REG_CTRL) & ~hwProtect & ~resetActive;
  assign ctrlRefused = wrAcc & (regIdx == svw_pkg::REG_CTRL) & (hwProtect | resetActive);
  assign clrWr       = wrAcc & (regIdx == svw_pkg::REG_CLEAR);
  assign enWr        = wrAcc & (regIdx == svw_pkg::REG_IRQEN);
  assign nvWr        = wrAcc & (regIdx == svw_pkg::REG_NVCMD);

  // one wait state then acknowledge
  always_ff @(posedge core_clk) begin
    if (rst) respond_ff <= 1'b0;
    else     respond_ff <= (avs_read | avs_write) & ~respond_ff;
  end

  // retained bits: rst loads CTRL_RESET, otherwise only bus writes change them; supervisor reset leaves them
  always_ff @(posedge core_clk) begin
    if (rst)         ctrl_ff <= svw_pkg::CTRL_RESET;
    else if (ctrlWr) ctrl_ff <= avs_writedata[2:0];
  end

  // ****************************************************************
  // reset sequencer and watchdog
  // ****************************************************************
  svw_pkg::svw_state_e state_ff, nxt_state;
  logic [31:0] holdCnt_ff, wdCnt_ff;
  logic        holdDone, wdExpire;
  assign resetActive = (state_ff != svw_pkg::SVW_RUN);
  assign holdDone    = (holdCnt_ff >= 32'(HOLD_CYC) - 32'h0000_0001);
  assign wdExpire    = wdEnabled & (wdCnt_ff >= wdLimitCyc - 32'h0000_0001) & ~startSeen;

  // next state: low supply wins, then hold, then watchdog
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      svw_pkg::SVW_RUN:  if (!pinClean_ff.supplyOk) nxt_state = svw_pkg::SVW_LOW;
                         else if (wdExpire)         nxt_state = svw_pkg::SVW_HOLD;
      svw_pkg::SVW_LOW:  if (pinClean_ff.supplyOk)  nxt_state = svw_pkg::SVW_HOLD;
      svw_pkg::SVW_HOLD: if (!pinClean_ff.supplyOk) nxt_state = svw_pkg::SVW_LOW;
                         else if (holdDone)         nxt_state = svw_pkg::SVW_RUN;
      default:           nxt_state = svw_pkg::SVW_LOW;
    endcase
  end

  // power-up starts in low-supply state
  always_ff @(posedge core_clk) begin
    if (rst) state_ff <= svw_pkg::SVW_LOW;
    else     state_ff <= nxt_state;
  end

  // hold counter runs only in hold state from internal timebase
  always_ff @(posedge core_clk) begin
    if (rst || state_ff != svw_pkg::SVW_HOLD) holdCnt_ff <= '0;
    else                                        holdCnt_ff <= holdCnt_ff + 32'h0000_0001;
  end

  // watchdog cleared in reset, when disabled, or on a start
  always_ff @(posedge core_clk) begin
    if (rst || resetActive || !wdEnabled || startSeen) wdCnt_ff <= '0;
    else                                                 wdCnt_ff <= wdCnt_ff + 32'h0000_0001;
  end

  // ****************************************************************
  // nonvolatile write cycle
  // ****************************************************************
  logic [31:0] nvCnt_ff;
  logic        nvBusy, nvStart;
  assign nvBusy  = (nvCnt_ff != 32'h0000_0000);
  assign nvStart = nvWr & ~nvBusy & ~resetActive;

  // a running cycle counts down regardless of supervisor reset; rst clears it
  always_ff @(posedge core_clk) begin
    if (rst)          nvCnt_ff <= '0;
    else if (nvStart) nvCnt_ff <= 32'(NV_CYC);
    else if (nvBusy)  nvCnt_ff <= nvCnt_ff - 32'h0000_0001;
  end

  // ****************************************************************
  // events and interrupt
  // ****************************************************************
  logic [svw_pkg::EV_W-1:0] status_ff, irqEn_ff, evSet;
  logic                     enterReset;
  assign enterReset = ~resetActive & (nxt_state != svw_pkg::SVW_RUN);
  assign evSet[svw_pkg::EV_WATCHDOG] = (state_ff == svw_pkg::SVW_RUN) & (nxt_state == svw_pkg::SVW_HOLD);
  assign evSet[svw_pkg::EV_BROWNOUT] = (state_ff != svw_pkg::SVW_LOW) & (nxt_state == svw_pkg::SVW_LOW);
  assign evSet[svw_pkg::EV_REFUSED]  = ctrlRefused | (nvWr & resetActive);
  assign evSet[svw_pkg::EV_ABORT]    = enterReset;

  // set wins over clear
  always_ff @(posedge core_clk) begin
    if (rst) status_ff <= '0;
    else     status_ff <= (status_ff & ~(clrWr ? avs_writedata[svw_pkg::EV_W-1:0] : '0)) | evSet;
  end

  always_ff @(posedge core_clk) begin
    if (rst)       irqEn_ff <= '0;
    else if (enWr) irqEn_ff <= avs_writedata[svw_pkg::EV_W-1:0];
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  logic [31:0] rdMux;
  assign rdMux = (regIdx == svw_pkg::REG_CTRL)   ? {29'h0, ctrl_ff} :
                 (regIdx == svw_pkg::REG_STATUS) ? {28'h0, status_ff} :
                 (regIdx == svw_pkg::REG_IRQEN)  ? {28'h0, irqEn_ff} :
                 (regIdx == svw_pkg::REG_STATE)  ? {27'h0, nvBusy, hwProtect, pinClean_ff.supplyOk, state_ff} :
                 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_readdata    <= '0;
      avs_waitrequest <= 1'b1;
      irq             <= 1'b0;
    end else begin
      avs_readdata    <= rdAcc ? rdMux : avs_readdata;
      avs_waitrequest <= ~((avs_read | avs_write) & ~respond_ff);
      irq             <= |((status_ff | evSet) & irqEn_ff);
    end
  end

  // open-drain pad: low variant pulls low when active, high variant drives when idle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      resetOut   <= 1'b0;
      resetOe    <= ~ACTIVE_HIGH;
      busAbort   <= 1'b0;
      busBlocked <= 1'b1;
    end else begin
      resetOut   <= 1'b0;
      resetOe    <= ACTIVE_HIGH ? (nxt_state == svw_pkg::SVW_RUN) : (nxt_state != svw_pkg::SVW_RUN);
      busAbort   <= enterReset;
      busBlocked <= (nxt_state != svw_pkg::SVW_RUN);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_low_supply_reset: assert property (@(posedge core_clk) disable iff (rst)
    !pinClean_ff.supplyOk |=> state_ff == svw_pkg::SVW_LOW) else $error("low supply not in reset");
  chk_hold_length: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == svw_pkg::SVW_HOLD && holdCnt_ff < 32'(HOLD_CYC) - 1) |=> state_ff != svw_pkg::SVW_RUN)
    else $error("hold ended early");
  chk_watchdog_fire: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == svw_pkg::SVW_RUN && pinClean_ff.supplyOk && wdExpire) |=> state_ff == svw_pkg::SVW_HOLD)
    else $error("watchdog expiry missed");
  chk_start_restart: assert property (@(posedge core_clk) disable iff (rst)
    startSeen |=> wdCnt_ff == 0) else $error("start did not restart watchdog");
  chk_protect_lock: assert property (@(posedge core_clk) disable iff (rst)
    hwProtect |=> ctrl_ff == $past(ctrl_ff)) else $error("ctrl changed under protection");
  chk_no_nv_start: assert property (@(posedge core_clk) disable iff (rst)
    (resetActive && !nvBusy) |=> !nvBusy) else $error("nv write started in reset");
  chk_nv_completes: assert property (@(posedge core_clk) disable iff (rst)
    (nvBusy && nvCnt_ff > 1) |=> nvCnt_ff == $past(nvCnt_ff) - 1) else $error("nv write cut short");
  chk_abort_pulse: assert property (@(posedge core_clk) disable iff (rst)
    (state_ff == svw_pkg::SVW_RUN && nxt_state != svw_pkg::SVW_RUN) |=> busAbort && busBlocked)
    else $error("abort missing on reset entry");
  chk_wd_cleared: assert property (@(posedge core_clk) disable iff (rst)
    resetActive |=> wdCnt_ff == 0) else $error("watchdog counted during reset");

  cov_watchdog_reset: cover property (@(posedge core_clk) disable iff (rst) evSet[svw_pkg::EV_WATCHDOG]);
  cov_brownout: cover property (@(posedge core_clk) disable iff (rst) evSet[svw_pkg::EV_BROWNOUT]);
  cov_refused: cover property (@(posedge core_clk) disable iff (rst) ctrlRefused);
  cov_release: cover property (@(posedge core_clk) disable iff (rst)
    state_ff == svw_pkg::SVW_HOLD ##1 state_ff == svw_pkg::SVW_RUN);
  cov_nv_in_reset: cover property (@(posedge core_clk) disable iff (rst) nvBusy && resetActive);

  // ****************************************************************
  // pad, bus and event checks
  // ****************************************************************
  // pad level matches the sequencer state in the same cycle
  chk_pad_level: assert property (@(posedge core_clk) disable iff (rst)
    resetOe == (ACTIVE_HIGH ? !resetActive : resetActive)) else $error("reset pad level wrong");
  chk_pad_data: assert property (@(posedge core_clk) disable iff (rst)
    resetOut == 1'b0) else $error("open-drain data not low");

  // supply recovery enters the hold interval with a fresh count
  chk_hold_start: assert property (@(posedge core_clk) disable iff (rst)
    ($rose(pinClean_ff.supplyOk) && state_ff == svw_pkg::SVW_LOW) |=>
    (state_ff == svw_pkg::SVW_HOLD && holdCnt_ff == 0)) else $error("hold did not start fresh");

  // disabled watchdog never counts
  chk_wd_quiet: assert property (@(posedge core_clk) disable iff (rst)
    !wdEnabled |=> wdCnt_ff == 0) else $error("disabled watchdog counted");
  chk_sel_short: assert property (@(posedge core_clk) disable iff (rst)
    wdSel == 2'b10 |-> wdLimitCyc == 32'(WD_SHORT_CYC)) else $error("short period decode wrong");
  chk_sel_enabled: assert property (@(posedge core_clk) disable iff (rst)
    wdEnabled |-> wdLimitCyc != 0) else $error("enabled watchdog has no limit");

  // control register comes back with the watchdog disabled
  chk_ctrl_default: assert property (@(posedge core_clk)
    rst |=> ctrl_ff == svw_pkg::CTRL_RESET) else $error("ctrl default wrong");

  // refused control writes leave the register and raise the flag
  chk_refuse_flag: assert property (@(posedge core_clk) disable iff (rst)
    ctrlRefused |=> status_ff[svw_pkg::EV_REFUSED]) else $error("refusal not flagged");
  chk_refuse_keep: assert property (@(posedge core_clk) disable iff (rst)
    ctrlRefused |=> ctrl_ff == $past(ctrl_ff)) else $error("refused write changed ctrl");

  // blocking level and single abort pulse
  chk_block_level: assert property (@(posedge core_clk) disable iff (rst)
    busBlocked == resetActive) else $error("bus block level wrong");
  chk_abort_once: assert property (@(posedge core_clk) disable iff (rst)
    busAbort |=> !busAbort) else $error("abort longer than one cycle");

  // a busy nonvolatile cycle ignores a new command
  chk_nv_busy_keep: assert property (@(posedge core_clk) disable iff (rst)
    (nvBusy && nvWr) |=> nvCnt_ff == $past(nvCnt_ff) - 1) else $error("busy nv cycle restarted");

  // one wait state, then read data held between reads
  chk_wait_one: assert property (@(posedge core_clk) disable iff (rst)
    ((avs_read || avs_write) && !respond_ff) |=> !avs_waitrequest) else $error("acknowledge late");
  chk_rdata_hold: assert property (@(posedge core_clk) disable iff (rst)
    !rdAcc |=> $stable(avs_readdata)) else $error("read data changed without read");

  // sticky status and masked interrupt
  chk_status_sticky: assert property (@(posedge core_clk) disable iff (rst)
    (status_ff[svw_pkg::EV_WATCHDOG] && !clrWr) |=> status_ff[svw_pkg::EV_WATCHDOG])
    else $error("status bit lost");
  chk_irq_masked: assert property (@(posedge core_clk) disable iff (rst)
    irqEn_ff == '0 |=> !irq) else $error("masked interrupt raised");

endmodule : svw_supervisor

//--- verif/svw_host_model.sv
/*
 * host model: 2-wire bus master that issues start conditions to keep the
 * watchdog quiet. assumes pulled-up open-drain lines and core_clk from the bench.
 */
`timescale 1ns/100ps
module svw_host_model (
  input  wire logic core_clk,
  input  wire logic startReq,
  input  wire logic badStart,
  input  wire logic slowReq,
  output logic      startDone,
  output logic      scl,
  output logic      sda
);
  // one half period of the link clock: 80 ns, or 160 ns when slow
  task automatic step();
    repeat (slowReq ? 8 : 4) @(posedge core_clk);
  endtask : step

  // frame sequencer; lines rest high on the pull-ups, clock still between frames
  initial begin
    scl       = 1'b1;
    sda       = 1'b1;
    startDone = 1'b0;
    forever begin
      @(posedge core_clk);
      if (startReq && !startDone) begin
        // a bad frame drops the clock first, so data falls while clock low
        if (badStart) scl <= 1'b0; else sda <= 1'b0;
        step();
        if (badStart) sda <= 1'b0; else scl <= 1'b0;
        step();
        sda <= 1'b1;
        step();
        scl       <= 1'b1;
        startDone <= 1'b1;
        @(posedge core_clk);
        startDone <= 1'b0;
      end
    end
  end
endmodule : svw_host_model

//--- verif/svw_supervisor_tb.sv
/*
 * self-checking bench for svw_supervisor: avalon register tasks and a host
 * model for start conditions. assumes scaled-down hold and watchdog counts.
 */
`timescale 1ns/100ps
module svw_supervisor_tb;
  localparam int HOLD    = 50;
  localparam int LIM [3] = '{400, 300, 200};
  logic        core_clk, rst, supplyAboveTrip, wpIn, startReq, badStart, slowReq;
  logic        avs_read, avs_write, startDone, scl, sda;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        resetOut, resetOe, busAbort, busBlocked, avs_waitrequest, irq;
  int          errors = 0, checks = 0, aborts = 0, cyc = 0, n, a0;

  svw_supervisor #(.HOLD_CYC(HOLD), .WD_LONG_CYC(400), .WD_MID_CYC(300), .WD_SHORT_CYC(200), .NV_CYC(40)) dut (
    .core_clk(core_clk), .rst(rst), .supplyAboveTrip(supplyAboveTrip), .sclIn(scl), .sdaIn(sda),
    .wpIn(wpIn), .resetOut(resetOut), .resetOe(resetOe), .busAbort(busAbort), .busBlocked(busBlocked),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

  svw_host_model host (.core_clk(core_clk), .startReq(startReq), .badStart(badStart), .slowReq(slowReq),
    .startDone(startDone), .scl(scl), .sda(sda));

  // ****************************************************************
  // clock, abort counter and timeout
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // counts abort pulses and cuts a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (busAbort === 1'b1) aborts <= aborts + 1;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk

  // one avalon access held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [2:0] idx, input logic [31:0] d);
    int k = 0;
    @(posedge core_clk);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin @(posedge core_clk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (k >= 50) begin
      errors++;
      stop_test();
    end
  endtask : bus

  task automatic wait_oe(input logic lvl, input int lim, output int k);
    k = 0;
    while (resetOe !== lvl && k < lim) begin @(posedge core_clk); k++; end
  endtask : wait_oe

  task automatic kick(input logic bad, input logic slow);
    int k = 0;
    @(posedge core_clk);
    startReq <= 1'b1;
    badStart <= bad;
    slowReq  <= slow;
    do begin @(posedge core_clk); k++; end while (startDone !== 1'b1 && k < 100);
    startReq <= 1'b0;
  endtask : kick

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rst, supplyAboveTrip, wpIn, startReq, badStart, slowReq, avs_read, avs_write} = 8'h80;
    avs_address   = 5'h0;
    avs_writedata = 32'h0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk(resetOe, 1, "reset at power-up");
    chk(resetOut, 0, "open-drain data low");
    chk(busBlocked, 1, "bus blocked");
    supplyAboveTrip <= 1'b1;
    repeat (HOLD - 10) @(posedge core_clk);
    chk(resetOe, 1, "power-up hold");
    wait_oe(0, 30, n);
    chk(resetOe, 0, "power-up release");
    bus(0, svw_pkg::REG_CTRL, 0);
    chk(rd, 32'h3, "select default");
    bus(0, 3'h7, 0);
    chk(rd, 32'h0, "unmapped read");
    bus(1, svw_pkg::REG_CLEAR, 32'hF);
    repeat (600) @(posedge core_clk);
    chk(resetOe, 0, "watchdog disabled");
    $display("test power-up done");
    for (int i = 0; i < 3; i++) begin
      bus(1, svw_pkg::REG_CTRL, i);
      kick(0, 0);
      wait_oe(1, 1000, n);
      chk(n >= LIM[i] - 20 && n <= LIM[i] + 8, 1, "watchdog period");
      wait_oe(0, HOLD + 20, n);
    end
    bus(0, svw_pkg::REG_STATUS, 0);
    chk(rd[0], 1, "watchdog event");
    chk(aborts > 0, 1, "abort on timeout");
    for (int i = 0; i < 4; i++) begin
      kick(0, i[0]);
      repeat (100) @(posedge core_clk);
      chk(resetOe, 0, "start restarts watchdog");
    end
    kick(1, 0);
    wait_oe(1, 130, n);
    chk(resetOe, 1, "fall with clock low ignored");
    wait_oe(0, HOLD + 20, n);
    bus(1, svw_pkg::REG_CTRL, 32'h3);
    $display("test watchdog done");
    bus(1, svw_pkg::REG_IRQEN, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(irq, 1, "irq raised");
    bus(1, svw_pkg::REG_IRQEN, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(irq, 0, "irq masked");
    bus(1, svw_pkg::REG_IRQEN, 32'h1);
    bus(1, svw_pkg::REG_CLEAR, 32'hF);
    repeat (2) @(posedge core_clk);
    chk(irq, 0, "irq cleared");
    bus(0, svw_pkg::REG_STATUS, 0);
    chk(rd[3:0], 4'h0, "status cleared");
    $display("test interrupt done");
    bus(1, svw_pkg::REG_CTRL, 32'h5);
    wpIn <= 1'b1;
    repeat (5) @(posedge core_clk);
    bus(1, svw_pkg::REG_CTRL, 32'h3);
    bus(0, svw_pkg::REG_CTRL, 0);
    chk(rd, 32'h5, "protected write refused");
    bus(0, svw_pkg::REG_STATUS, 0);
    chk(rd[2], 1, "refusal flagged");
    bus(0, svw_pkg::REG_STATE, 0);
    chk(rd[3], 1, "protection on");
    wpIn <= 1'b0;
    repeat (5) @(posedge core_clk);
    bus(1, svw_pkg::REG_CTRL, 32'h3);
    bus(0, svw_pkg::REG_CTRL, 0);
    chk(rd, 32'h3, "unprotected write");
    $display("test protect done");
    bus(1, svw_pkg::REG_CLEAR, 32'hF);
    a0 = aborts;
    bus(1, svw_pkg::REG_NVCMD, 32'h1);
    supplyAboveTrip <= 1'b0;
    wait_oe(1, 10, n);
    chk(resetOe, 1, "brownout reset");
    chk(busBlocked, 1, "bus blocked in brownout");
    bus(0, svw_pkg::REG_STATE, 0);
    chk(rd[4], 1, "running write completes");
    bus(1, svw_pkg::REG_NVCMD, 32'h1);
    repeat (45) @(posedge core_clk);
    bus(0, svw_pkg::REG_STATE, 0);
    chk(rd[4], 0, "no write starts in reset");
    bus(0, svw_pkg::REG_STATUS, 0);
    chk(rd[2:1], 2'h3, "brownout and refusal");
    chk(aborts > a0, 1, "abort on brownout");
    supplyAboveTrip <= 1'b1;
    repeat (HOLD - 10) @(posedge core_clk);
    chk(resetOe, 1, "brownout hold");
    wait_oe(0, 30, n);
    chk(resetOe, 0, "brownout release");
    $display("test brownout done");
    stop_test();
  end
endmodule : svw_supervisor_tb
